// ===== design/usb_desc_pipes.sv
// Built-in descriptor return, configuration state and pipe enables.
`timescale 1ns/1ns
`default_nettype none

// Contract
// RULE1 - One configuration, one interface, alternate settings zero to two.
// RULE2 - Endpoint zero is the control pipe everywhere, eight-byte packets.
// RULE3 - Every setting has bulk OUT endpoint one, 64-byte packets.
// RULE4 - Settings one and two have bulk IN 0x82, 64 bytes; setting zero none.
// RULE5 - Only setting two has interrupt endpoint 0x83, four bytes, every frame.
// RULE6 - Configuration descriptor is nine bytes, type two, total length 78.
// RULE7 - Configuration value is one; Set Configuration with one selects it.
// RULE8 - Attribute byte is 0x80, bus powered only.
// RULE9 - Maximum power field is 0x31, meaning 98 mA.
// RULE10 - Setting zero is printer class, subclass one, protocol one, one endpoint.
// RULE11 - Setting one is printer, bidirectional protocol two, two endpoints.
// RULE12 - Setting two is vendor class 0xFF, subclass zero, protocol 0xFF, three endpoints.
// RULE13 - Interface descriptors: nine bytes, type four, number zero, own setting.
// RULE14 - Endpoint descriptors: seven bytes, type five; bulk interval zero.
// RULE15 - Configuration string index is zero.
// RULE16 - Control pipe is the default pipe for standard, class and vendor traffic.
// RULE17 - Four pipes, each enabled only in its listed settings.
// RULE18 - Built-in descriptors return only when no external source is present.
// RULE19 - External configuration block starts at word address 0x13.
// RULE20 - Descriptor return discards pending bulk IN data and takes its buffer.
// RULE21 - A short request returns only the requested number of bytes.
module usb_desc_pipes (
    // Clock and reset.
    input wire logic mclk,
    input wire logic reset,
    // Configuration descriptor request.
    input wire logic desc_req,
    input wire logic [15:0] req_len,
    input wire logic ext_src_present,
    output logic desc_done,
    // External descriptor source.
    output logic ext_fetch,
    output logic [7:0] ext_word_addr,
    // Shared bulk IN buffer.
    output logic bulk_in_flush,
    // Descriptor byte stream.
    output logic tx_valid,
    output logic [7:0] tx_data,
    output logic tx_last,
    output logic tx_pkt_end,
    input wire logic tx_ready,
    // Standard configuration requests.
    input wire logic set_config,
    input wire logic [7:0] config_value,
    input wire logic set_intf,
    input wire logic [7:0] alt_value,
    output logic req_stall,
    // Device state and pipe enables.
    output logic configured,
    output logic [1:0] cur_alt,
    output logic [7:0] ep0_mps,
    output logic ep_ctrl_en,
    output logic ep_bulk_out_en,
    output logic ep_bulk_in_en,
    output logic ep_intr_en
);

    typedef enum logic {st_idle, st_send} desc_state_t;

    function automatic logic [6:0] clip_len(input logic [15:0] len);
        return (len > usb_desc_pkg::TOTAL_LEN) ? usb_desc_pkg::TOTAL_LEN[6:0] : len[6:0];
    endfunction

    desc_state_t state_r;
    logic [6:0] idx_r;
    logic [6:0] send_len_r;
    logic [7:0] data_r;
    logic [6:0] rom_idx;
    logic [7:0] rom_data;
    logic accept;
    logic beat;
    logic configured_r;
    logic [1:0] alt_r;

    ////////////////////////////////////////////////////////////////////////////////
    // Request acceptance and byte stream.

    assign accept = desc_req && (state_r == st_idle);
    assign beat = tx_valid && tx_ready;
    assign tx_valid = (state_r == st_send);
    assign tx_last = tx_valid && (idx_r == send_len_r - 7'h01);
    assign tx_pkt_end = tx_last || (tx_valid && idx_r[2:0] == 3'h7); // see RULE2
    assign tx_data = data_r;
    assign rom_idx = accept ? 7'h00 : idx_r + 7'h01;

    usb_desc_rom u_rom (
        .idx(rom_idx),
        .data(rom_data)
    );

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            state_r <= st_idle;
        end else begin
            unique case (state_r)
                st_idle: begin
                    if (accept && !ext_src_present && req_len != 16'h0000) begin // see RULE18
                        state_r <= st_send;
                    end
                end
                st_send: begin
                    if (beat && tx_last) begin
                        state_r <= st_idle;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            idx_r <= 7'h00;
            send_len_r <= 7'h00;
            data_r <= 8'h00;
        end else if (accept) begin
            idx_r <= 7'h00;
            send_len_r <= clip_len(req_len); // see RULE21
            data_r <= rom_data;
        end else if (beat) begin
            idx_r <= rom_idx;
            data_r <= rom_data;
        end
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            bulk_in_flush <= 1'b0;
            ext_fetch <= 1'b0;
            ext_word_addr <= 8'h00;
            desc_done <= 1'b0;
        end else begin
            bulk_in_flush <= accept; // see RULE20
            ext_fetch <= accept && ext_src_present;
            if (accept && ext_src_present) begin
                ext_word_addr <= usb_desc_pkg::EXT_CFG_WORD; // see RULE19
            end
            desc_done <= (beat && tx_last) ||
                         (accept && !ext_src_present && req_len == 16'h0000);
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Configuration and alternate setting.

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            configured_r <= 1'b0;
            alt_r <= usb_desc_pkg::printer_oneway_setting;
            req_stall <= 1'b0;
        end else begin
            req_stall <= 1'b0;
            if (set_config) begin
                if (config_value == usb_desc_pkg::CFG_VALUE) begin // see RULE7
                    configured_r <= 1'b1;
                    alt_r <= usb_desc_pkg::printer_oneway_setting;
                end else if (config_value == 8'h00) begin
                    configured_r <= 1'b0;
                    alt_r <= usb_desc_pkg::printer_oneway_setting;
                end else begin
                    req_stall <= 1'b1;
                end
            end else if (set_intf) begin
                if (configured_r && alt_value <= usb_desc_pkg::ALT_MAX) begin // see RULE1
                    alt_r <= alt_value[1:0];
                end else begin
                    req_stall <= 1'b1;
                end
            end
        end
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            ep_ctrl_en <= 1'b0;
            ep_bulk_out_en <= 1'b0;
            ep_bulk_in_en <= 1'b0;
            ep_intr_en <= 1'b0;
            ep0_mps <= 8'h00;
        end else begin
            ep_ctrl_en <= 1'b1; // see RULE16
            ep0_mps <= usb_desc_pkg::EP0_MPS; // see RULE2
            ep_bulk_out_en <= configured_r; // see RULE17
            ep_bulk_in_en <= configured_r && alt_r != usb_desc_pkg::printer_oneway_setting;
            ep_intr_en <= configured_r && alt_r == usb_desc_pkg::vendor_setting;
        end
    end

    assign configured = configured_r;
    assign cur_alt = alt_r;

    ////////////////////////////////////////////////////////////////////////////////
    // Checks.

    logic [6:0] beat_cnt;
    logic [15:0] len_seen;

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            beat_cnt <= 7'h00;
            len_seen <= 16'h0000;
        end else if (accept) begin
            beat_cnt <= 7'h00;
            len_seen <= req_len;
        end else if (beat) begin
            beat_cnt <= beat_cnt + 7'h01;
        end
    end

    property p_alt_range;
        @(posedge mclk) disable iff (reset) set_intf && !set_config && alt_value > 8'h02
            |=> req_stall && $stable(cur_alt);
    endproperty
    a_alt_range: assert property (p_alt_range) else $error("Alt above two accepted."); // see RULE1

    property p_bulk_in;
        @(posedge mclk) disable iff (reset)
            ##1 ep_bulk_in_en == ($past(configured) && $past(cur_alt) != 2'h0);
    endproperty
    a_bulk_in: assert property (p_bulk_in) else $error("Bulk IN enable wrong."); // see RULE4

    property p_intr;
        @(posedge mclk) disable iff (reset) ep_intr_en |-> ep_bulk_in_en && ep_bulk_out_en;
    endproperty
    a_intr: assert property (p_intr) else $error("Interrupt pipe without bulk pipes."); // see RULE5

    property p_config;
        @(posedge mclk) disable iff (reset) set_config && config_value == 8'h01 |=> configured ##1 ep_bulk_out_en;
    endproperty
    a_config: assert property (p_config) else $error("Set Configuration one ignored."); // see RULE7

    property p_flush;
        @(posedge mclk) disable iff (reset) desc_req && !tx_valid |=> bulk_in_flush;
    endproperty
    a_flush: assert property (p_flush) else $error("Bulk IN not flushed."); // see RULE20

    property p_ext;
        @(posedge mclk) disable iff (reset) desc_req && !tx_valid && ext_src_present
            |=> ext_fetch && ext_word_addr == 8'h13 ##0 (!tx_valid) [*3];
    endproperty
    a_ext: assert property (p_ext) else $error("External fetch wrong."); // see RULE18

    property p_first;
        @(posedge mclk) disable iff (reset) $rose(tx_valid) |-> tx_data == 8'h09;
    endproperty
    a_first: assert property (p_first) else $error("First byte not nine."); // see RULE6

    property p_len;
        @(posedge mclk) disable iff (reset) tx_last && tx_ready
            |-> 16'(beat_cnt) + 16'h0001 == ((len_seen > 16'h004E) ? 16'h004E : len_seen);
    endproperty
    a_len: assert property (p_len) else $error("Returned length wrong."); // see RULE21

    property p_pkt;
        @(posedge mclk) disable iff (reset) tx_valid && tx_ready && beat_cnt[2:0] == 3'h7 |-> tx_pkt_end;
    endproperty
    a_pkt: assert property (p_pkt) else $error("Packet over eight bytes."); // see RULE2

    c_full: cover property (@(posedge mclk) disable iff (reset) tx_last && tx_ready && beat_cnt == 7'h4D);
    c_short: cover property (@(posedge mclk) disable iff (reset) tx_last && tx_ready && beat_cnt < 7'h08);
    c_vendor: cover property (@(posedge mclk) disable iff (reset) ep_intr_en);
    c_ext: cover property (@(posedge mclk) disable iff (reset) ext_fetch);

endmodule

`default_nettype wire

// ===== design/usb_desc_pkg.sv
// Constants for the built-in configuration descriptor set and the endpoint map.
package usb_desc_pkg;

    // Configuration descriptor.
    localparam logic [7:0] CFG_LEN = 8'h09;
    localparam logic [7:0] TYPE_CFG = 8'h02;
    localparam logic [15:0] TOTAL_LEN = 16'h004E;
    localparam logic [7:0] NUM_INTF = 8'h01;
    localparam logic [7:0] CFG_VALUE = 8'h01;
    localparam logic [7:0] CFG_STR_IDX = 8'h00;
    localparam logic [7:0] CFG_ATTR = 8'h80;
    localparam logic [7:0] MAX_POWER = 8'h31;

    // Interface descriptors.
    localparam logic [7:0] INTF_LEN = 8'h09;
    localparam logic [7:0] TYPE_INTF = 8'h04;
    localparam logic [7:0] INTF_NUM = 8'h00;
    localparam logic [7:0] INTF_STR_IDX = 8'h00;
    localparam logic [7:0] PRN_CLASS = 8'h07;
    localparam logic [7:0] PRN_SUBCLASS = 8'h01;
    localparam logic [7:0] PROTO_ONEWAY = 8'h01;
    localparam logic [7:0] PROTO_TWOWAY = 8'h02;
    localparam logic [7:0] VND_CLASS = 8'hFF;
    localparam logic [7:0] VND_SUBCLASS = 8'h00;
    localparam logic [7:0] VND_PROTO = 8'hFF;
    localparam logic [7:0] NEPS_ONE = 8'h01;
    localparam logic [7:0] NEPS_TWO = 8'h02;
    localparam logic [7:0] NEPS_THREE = 8'h03;

    // Alternate settings.
    localparam logic [1:0] printer_oneway_setting = 2'h0;
    localparam logic [1:0] printer_twoway_setting = 2'h1;
    localparam logic [1:0] vendor_setting = 2'h2;
    localparam logic [7:0] ALT_MAX = 8'h02;

    // Endpoint descriptors.
    localparam logic [7:0] EP_LEN = 8'h07;
    localparam logic [7:0] TYPE_EP = 8'h05;
    localparam logic [7:0] EP_OUT_ADDR = 8'h01;
    localparam logic [7:0] EP_IN_ADDR = 8'h82;
    localparam logic [7:0] EP_INT_ADDR = 8'h83;
    localparam logic [7:0] ATTR_BULK = 8'h02;
    localparam logic [7:0] ATTR_INT = 8'h03;
    localparam logic [15:0] MPS_BULK = 16'h0040;
    localparam logic [15:0] MPS_INT = 16'h0004;
    localparam logic [7:0] IVAL_BULK = 8'h00;
    localparam logic [7:0] IVAL_INT = 8'h01;
    localparam logic [7:0] EP0_MPS = 8'h08;

    // Byte positions of each descriptor inside the 78-byte return.
    localparam logic [6:0] SEG_IF0 = 7'h09;
    localparam logic [6:0] SEG_IF0_OUT = 7'h12;
    localparam logic [6:0] SEG_IF1 = 7'h19;
    localparam logic [6:0] SEG_IF1_OUT = 7'h22;
    localparam logic [6:0] SEG_IF1_IN = 7'h29;
    localparam logic [6:0] SEG_IF2 = 7'h30;
    localparam logic [6:0] SEG_IF2_OUT = 7'h39;
    localparam logic [6:0] SEG_IF2_IN = 7'h40;
    localparam logic [6:0] SEG_IF2_INT = 7'h47;

    // External storage start of the configuration block, in words.
    localparam logic [7:0] EXT_CFG_WORD = 8'h13;

endpackage

// ===== design/usb_desc_rom.sv
// Constant byte table of the built-in configuration descriptor set.
`timescale 1ns/1ns
`default_nettype none

module usb_desc_rom (
    // Byte index and byte value.
    input wire logic [6:0] idx,
    output logic [7:0] data
);

    function automatic logic [7:0] intf_byte(input logic [3:0] off, input logic [1:0] alt,
                                             input logic [7:0] neps, input logic [7:0] cls,
                                             input logic [7:0] sub, input logic [7:0] proto);
        logic [7:0] b;
        b = 8'h00;
        unique case (off)
            4'h0: b = usb_desc_pkg::INTF_LEN;
            4'h1: b = usb_desc_pkg::TYPE_INTF;
            4'h2: b = usb_desc_pkg::INTF_NUM;
            4'h3: b = {6'h00, alt};
            4'h4: b = neps;
            4'h5: b = cls;
            4'h6: b = sub;
            4'h7: b = proto;
            default: b = usb_desc_pkg::INTF_STR_IDX;
        endcase
        return b;
    endfunction

    function automatic logic [7:0] ep_byte(input logic [2:0] off, input logic [7:0] addr,
                                           input logic [7:0] attr, input logic [15:0] mps,
                                           input logic [7:0] ival);
        logic [7:0] b;
        b = 8'h00;
        unique case (off)
            3'h0: b = usb_desc_pkg::EP_LEN;
            3'h1: b = usb_desc_pkg::TYPE_EP;
            3'h2: b = addr;
            3'h3: b = attr;
            3'h4: b = mps[7:0];
            3'h5: b = mps[15:8];
            default: b = ival;
        endcase
        return b;
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    always_comb begin
        logic [6:0] o;
        o = 7'h00;
        data = 8'h00;
        if (idx < usb_desc_pkg::SEG_IF0) begin
            unique case (idx[3:0])
                4'h0: data = usb_desc_pkg::CFG_LEN; // see RULE6
                4'h1: data = usb_desc_pkg::TYPE_CFG; // see RULE6
                4'h2: data = usb_desc_pkg::TOTAL_LEN[7:0]; // see RULE6
                4'h3: data = usb_desc_pkg::TOTAL_LEN[15:8];
                4'h4: data = usb_desc_pkg::NUM_INTF; // see RULE1
                4'h5: data = usb_desc_pkg::CFG_VALUE; // see RULE7
                4'h6: data = usb_desc_pkg::CFG_STR_IDX; // see RULE15
                4'h7: data = usb_desc_pkg::CFG_ATTR; // see RULE8
                default: data = usb_desc_pkg::MAX_POWER; // see RULE9
            endcase
        end else if (idx < usb_desc_pkg::SEG_IF0_OUT) begin
            o = idx - usb_desc_pkg::SEG_IF0;
            data = intf_byte(o[3:0], usb_desc_pkg::printer_oneway_setting, // see RULE13
                             usb_desc_pkg::NEPS_ONE, usb_desc_pkg::PRN_CLASS, // see RULE10
                             usb_desc_pkg::PRN_SUBCLASS, usb_desc_pkg::PROTO_ONEWAY);
        end else if (idx < usb_desc_pkg::SEG_IF1) begin
            o = idx - usb_desc_pkg::SEG_IF0_OUT;
            data = ep_byte(o[2:0], usb_desc_pkg::EP_OUT_ADDR, usb_desc_pkg::ATTR_BULK, // see RULE3
                           usb_desc_pkg::MPS_BULK, usb_desc_pkg::IVAL_BULK); // see RULE14
        end else if (idx < usb_desc_pkg::SEG_IF1_OUT) begin
            o = idx - usb_desc_pkg::SEG_IF1;
            data = intf_byte(o[3:0], usb_desc_pkg::printer_twoway_setting,
                             usb_desc_pkg::NEPS_TWO, usb_desc_pkg::PRN_CLASS, // see RULE11
                             usb_desc_pkg::PRN_SUBCLASS, usb_desc_pkg::PROTO_TWOWAY);
        end else if (idx < usb_desc_pkg::SEG_IF1_IN) begin
            o = idx - usb_desc_pkg::SEG_IF1_OUT;
            data = ep_byte(o[2:0], usb_desc_pkg::EP_OUT_ADDR, usb_desc_pkg::ATTR_BULK,
                           usb_desc_pkg::MPS_BULK, usb_desc_pkg::IVAL_BULK);
        end else if (idx < usb_desc_pkg::SEG_IF2) begin
            o = idx - usb_desc_pkg::SEG_IF1_IN;
            data = ep_byte(o[2:0], usb_desc_pkg::EP_IN_ADDR, usb_desc_pkg::ATTR_BULK, // see RULE4
                           usb_desc_pkg::MPS_BULK, usb_desc_pkg::IVAL_BULK);
        end else if (idx < usb_desc_pkg::SEG_IF2_OUT) begin
            o = idx - usb_desc_pkg::SEG_IF2;
            data = intf_byte(o[3:0], usb_desc_pkg::vendor_setting,
                             usb_desc_pkg::NEPS_THREE, usb_desc_pkg::VND_CLASS, // see RULE12
                             usb_desc_pkg::VND_SUBCLASS, usb_desc_pkg::VND_PROTO);
        end else if (idx < usb_desc_pkg::SEG_IF2_IN) begin
            o = idx - usb_desc_pkg::SEG_IF2_OUT;
            data = ep_byte(o[2:0], usb_desc_pkg::EP_OUT_ADDR, usb_desc_pkg::ATTR_BULK,
                           usb_desc_pkg::MPS_BULK, usb_desc_pkg::IVAL_BULK);
        end else if (idx < usb_desc_pkg::SEG_IF2_INT) begin
            o = idx - usb_desc_pkg::SEG_IF2_IN;
            data = ep_byte(o[2:0], usb_desc_pkg::EP_IN_ADDR, usb_desc_pkg::ATTR_BULK,
                           usb_desc_pkg::MPS_BULK, usb_desc_pkg::IVAL_BULK);
        end else if (idx < usb_desc_pkg::TOTAL_LEN[6:0]) begin
            o = idx - usb_desc_pkg::SEG_IF2_INT;
            data = ep_byte(o[2:0], usb_desc_pkg::EP_INT_ADDR, usb_desc_pkg::ATTR_INT, // see RULE5
                           usb_desc_pkg::MPS_INT, usb_desc_pkg::IVAL_INT);
        end
    end

endmodule

`default_nettype wire

// ===== verification/usb_host_model.sv
// Host-side consumer of the descriptor byte stream, with optional stalls.
`timescale 1ns/1ns
`default_nettype none

module usb_host_model (
    // Clock and reset.
    input wire logic mclk,
    input wire logic reset,
    // Stall control from the bench.
    input wire logic slow,
    // Descriptor byte stream.
    input wire logic tx_valid,
    input wire logic [7:0] tx_data,
    input wire logic tx_last,
    input wire logic tx_pkt_end,
    output logic tx_ready
);
    logic [9:0] rx_q[$];

    ////////////////////////////////////////////////////////////////////////////////////////////
    // A slow host takes a byte only every other cycle.
    always @(negedge mclk or posedge reset) begin
        if (reset) begin
            tx_ready <= 1'b0;
        end else begin
            tx_ready <= slow ? ~tx_ready : 1'b1;
        end
    end

    // Each accepted byte is kept with its last and packet-end marks.
    always @(posedge mclk) begin
        if (!reset && tx_valid === 1'b1 && tx_ready === 1'b1) begin
            rx_q.push_back({tx_last, tx_pkt_end, tx_data});
        end
    end
endmodule
`default_nettype wire

// ===== verification/usb_descriptor_set_and_pipes_tb.sv
// Self-checking testbench of the descriptor return and pipe enables.
`timescale 1ns/1ns
`default_nettype none

module usb_descriptor_set_and_pipes_tb;
    logic mclk, reset, desc_req, ext_src_present, desc_done, ext_fetch, bulk_in_flush;
    logic tx_valid, tx_last, tx_pkt_end, tx_ready, set_config, set_intf, req_stall;
    logic configured, ep_ctrl_en, ep_bulk_out_en, ep_bulk_in_en, ep_intr_en, host_slow;
    logic [15:0] req_len;
    logic [7:0] ext_word_addr, tx_data, config_value, alt_value, ep0_mps;
    logic [1:0] cur_alt;
    logic [7:0] exp_q[$];
    int errors = 0;
    int total_checks = 0;
    int cycles = 0;

    usb_desc_pipes dut_u (.mclk(mclk), .reset(reset), .desc_req(desc_req), .req_len(req_len),
        .ext_src_present(ext_src_present), .desc_done(desc_done), .ext_fetch(ext_fetch),
        .ext_word_addr(ext_word_addr), .bulk_in_flush(bulk_in_flush), .tx_valid(tx_valid),
        .tx_data(tx_data), .tx_last(tx_last), .tx_pkt_end(tx_pkt_end), .tx_ready(tx_ready),
        .set_config(set_config), .config_value(config_value), .set_intf(set_intf),
        .alt_value(alt_value), .req_stall(req_stall), .configured(configured),
        .cur_alt(cur_alt), .ep0_mps(ep0_mps), .ep_ctrl_en(ep_ctrl_en),
        .ep_bulk_out_en(ep_bulk_out_en), .ep_bulk_in_en(ep_bulk_in_en), .ep_intr_en(ep_intr_en));

    usb_host_model host_u (.mclk(mclk), .reset(reset), .slow(host_slow), .tx_valid(tx_valid),
        .tx_data(tx_data), .tx_last(tx_last), .tx_pkt_end(tx_pkt_end), .tx_ready(tx_ready));

    ////////////////////////////////////////////////////////////////////////////////////////////
    always #4 mclk = ~mclk;

    always @(posedge mclk) begin
        cycles++;
        if (cycles == 6000) begin
            errors++;
            test_done();
        end
    end

    task automatic test_done();
        if (errors == 0 && total_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        total_checks++;
        if (got !== exp) begin
            errors++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////////////////////
    task automatic push_if(input logic [7:0] alt, input logic [7:0] n, input logic [7:0] c,
                           input logic [7:0] s, input logic [7:0] p);
        exp_q = {exp_q, 8'h09, 8'h04, 8'h00, alt, n, c, s, p, 8'h00};
    endtask

    task automatic push_ep(input logic [7:0] a, input logic [7:0] t, input logic [7:0] m,
                           input logic [7:0] iv);
        exp_q = {exp_q, 8'h07, 8'h05, a, t, m, 8'h00, iv};
    endtask

    task automatic run_req(input logic [15:0] len);
        int i;
        host_u.rx_q.delete();
        desc_req = 1'b1;
        req_len = len;
        ext_src_present = 1'b0;
        @(negedge mclk);
        desc_req = 1'b0;
        check("bulk_in_flush", 16'h0001, 16'(bulk_in_flush));
        i = 0;
        while (desc_done !== 1'b1 && i < 400) begin
            @(negedge mclk);
            i++;
        end
        check("desc_done", 16'h0001, 16'(desc_done));
        @(negedge mclk);
    endtask

    task automatic compare_stream(input int n);
        logic [9:0] e;
        check("byte count", 16'(n), 16'(host_u.rx_q.size()));
        for (int i = 0; i < n && i < host_u.rx_q.size(); i++) begin
            e = {i == n - 1, (i % 8 == 7) || (i == n - 1), exp_q[i]};
            check($sformatf("byte %0d", i), 16'(e), 16'(host_u.rx_q[i]));
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////////////////////
    task automatic t_reset_state();
        @(negedge mclk);
        check("ep0_mps", 16'h0008, 16'(ep0_mps));
        check("ep_ctrl_en", 16'h0001, 16'(ep_ctrl_en));
        check("ext_word_addr", 16'h0000, 16'(ext_word_addr));
    endtask

    task automatic t_full_read();
        exp_q = {8'h09, 8'h02, 8'h4E, 8'h00, 8'h01, 8'h01, 8'h00, 8'h80, 8'h31};
        push_if(8'h00, 8'h01, 8'h07, 8'h01, 8'h01);
        push_ep(8'h01, 8'h02, 8'h40, 8'h00);
        push_if(8'h01, 8'h02, 8'h07, 8'h01, 8'h02);
        push_ep(8'h01, 8'h02, 8'h40, 8'h00);
        push_ep(8'h82, 8'h02, 8'h40, 8'h00);
        push_if(8'h02, 8'h03, 8'hFF, 8'h00, 8'hFF);
        push_ep(8'h01, 8'h02, 8'h40, 8'h00);
        push_ep(8'h82, 8'h02, 8'h40, 8'h00);
        push_ep(8'h83, 8'h03, 8'h04, 8'h01);
        host_slow = 1'b1;
        run_req(16'h004E);
        compare_stream(78);
        host_slow = 1'b0;
    endtask

    task automatic t_short_reads();
        logic [15:0] lens[4] = '{16'h0005, 16'h0008, 16'h0000, 16'h00FF};
        foreach (lens[k]) begin
            run_req(lens[k]);
            compare_stream(lens[k] > 16'h004E ? 78 : int'(lens[k]));
        end
    endtask

    task automatic t_ext_source();
        host_u.rx_q.delete();
        desc_req = 1'b1;
        req_len = 16'h004E;
        ext_src_present = 1'b1;
        @(negedge mclk);
        desc_req = 1'b0;
        check("ext_fetch", 16'h0001, 16'(ext_fetch));
        check("bulk_in_flush", 16'h0001, 16'(bulk_in_flush));
        repeat (4) begin
            @(negedge mclk);
            check("tx_valid", 16'h0000, 16'(tx_valid));
        end
        check("ext_word_addr", 16'h0013, 16'(ext_word_addr));
        ext_src_present = 1'b0;
    endtask

    task automatic cfg_op(input logic sc, input logic si, input logic [7:0] v,
                          input logic stall, input logic cfgd, input logic [1:0] alt);
        set_config = sc;
        set_intf = si;
        config_value = v;
        alt_value = v;
        @(negedge mclk);
        set_config = 1'b0;
        set_intf = 1'b0;
        check("req_stall", 16'(stall), 16'(req_stall));
        check("configured", 16'(cfgd), 16'(configured));
        check("cur_alt", 16'(alt), 16'(cur_alt));
        @(negedge mclk);
        check("pipe enables", 16'({1'b1, cfgd, cfgd && alt != 2'h0, cfgd && alt == 2'h2}),
              16'({ep_ctrl_en, ep_bulk_out_en, ep_bulk_in_en, ep_intr_en}));
    endtask

    task automatic t_config();
        cfg_op(1'b0, 1'b1, 8'h01, 1'b1, 1'b0, 2'h0);
        cfg_op(1'b1, 1'b0, 8'h02, 1'b1, 1'b0, 2'h0);
        cfg_op(1'b1, 1'b0, 8'h01, 1'b0, 1'b1, 2'h0);
        for (int a = 0; a < 3; a++) begin
            cfg_op(1'b0, 1'b1, 8'(a), 1'b0, 1'b1, 2'(a));
        end
        cfg_op(1'b0, 1'b1, 8'h03, 1'b1, 1'b1, 2'h2);
        cfg_op(1'b1, 1'b0, 8'h01, 1'b0, 1'b1, 2'h0);
        cfg_op(1'b1, 1'b0, 8'h00, 1'b0, 1'b0, 2'h0);
    endtask

    ////////////////////////////////////////////////////////////////////////////////////////////
    initial begin
        mclk = 1'b0;
        reset = 1'b1;
        desc_req = 1'b0;
        req_len = 16'h0000;
        ext_src_present = 1'b0;
        set_config = 1'b0;
        set_intf = 1'b0;
        config_value = 8'h00;
        alt_value = 8'h00;
        host_slow = 1'b0;
        repeat (12) @(negedge mclk);
        reset = 1'b0;
        t_reset_state();
        t_full_read();
        t_short_reads();
        t_ext_source();
        t_config();
        test_done();
    end
endmodule
`default_nettype wire
